// *** edac_glue_consts.svh ***
// Timing counts, field positions and encodings for the dual-port EDAC memory glue.
`ifndef EDAC_GLUE_CONSTS_SVH
`define EDAC_GLUE_CONSTS_SVH
`define READ_CLKS        4'h8
`define READ_MON_CLKS    4'h7
`define WRITE_CLKS       4'h5
`define BYTE_WRITE_CLKS  4'h9
`define BURST_WORD_CLKS  4'h4
`define SCRUB_CLKS       4'h6
`define SCRUB_ERR_CLKS   4'h8
`define SCRUB_CHECK_CNT  4'h3
`define PRECHARGE_CLKS   4'h3
`define FIXUP_CLKS       4'h2
`define ERR_SAMPLE_BACK  4'h2
`define BURST_EXTRA      2'h3
`define BANK_BIT         4
`define NIB_HI           3
`define NIB_LO           2
`define SIZ_LONG         2'h0
`define SIZ_BYTE         2'h1
`define SIZ_WORD         2'h2
`define SIZ_TRIPLE       2'h3
`define MASK_ALL         4'hf
`define MASK_NONE        4'h0
`define PORT_A           1'h0
`define PORT_B           1'h1
`endif

// *** edac_glue_pkg.sv ***
// Types shared by the dual-port EDAC memory glue and its arbiter.
package edac_glue_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ACCESS = 3'b001,
    ST_BURST  = 3'b010,
    ST_SCRUB  = 3'b011,
    ST_FIXUP  = 3'b100
  } state_t;
  typedef enum logic [1:0] {
    OWN_NONE = 2'b00,
    OWN_A    = 2'b01,
    OWN_B    = 2'b10,
    OWN_REF  = 2'b11
  } owner_t;
endpackage

// *** arb_if.sv ***
// Request and grant signals between the glue sequencer and its arbiter.
`timescale 1ns/1ps
`default_nettype none
interface arb_if;
  import edac_glue_pkg::*;
  logic   [1:0] req;
  logic         req_ref;
  logic         ready;
  owner_t       grant;
  modport arbiter (input req, input req_ref, input ready, output grant);
  modport client  (output req, output req_ref, output ready, input grant);
endinterface
`default_nettype wire

// *** edac_arbiter.sv ***
// Three-way arbiter: refresh first, then the port that used memory last.
`timescale 1ns/1ps
`default_nettype none
module edac_arbiter
  import edac_glue_pkg::*;
(
  input  wire logic clk,
  input  wire logic sys_rst,
  arb_if.arbiter    arb
);
  logic last_b_q;
  logic last_b_d;
  logic both;

  // Refresh is served first so scrubbing cannot be starved by busy ports.
  assign both = arb.req[0] & arb.req[1];
  always_comb begin
    arb.grant = OWN_NONE;
    if (arb.ready) begin
      if (arb.req_ref) begin
        arb.grant = OWN_REF;
      end else if (both) begin
        arb.grant = last_b_q ? OWN_B : OWN_A; // R6
      end else if (arb.req[0]) begin
        arb.grant = OWN_A;
      end else if (arb.req[1]) begin
        arb.grant = OWN_B;
      end
    end
  end

  assign last_b_d = (arb.grant == OWN_B) ? 1'b1 : (arb.grant == OWN_A) ? 1'b0 : last_b_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_b_q <= 1'b0;
    end else begin
      last_b_q <= last_b_d;
    end
  end
endmodule
`default_nettype wire

// *** edac_glue.sv ***
// Dual-port sequencer that shares one error-corrected DRAM between two processors.
// Behaviour
// R1 - Correcting mode: single read lasts eight clocks, single-bit errors corrected on the way.
// R2 - Full-word write lasts five clocks.
// R3 - Partial byte write lasts nine clocks.
// R4 - Each further burst word lasts four clocks.
// R5 - Refresh scrubs one word: six clocks clean, eight with error and write-back.
// R6 - With both ports requesting, the most recent user wins.
// R7 - Every processor cycle ends with its synchronous termination strobe; a retried monitoring-mode read ends with fault and suspend instead.
// R8 - Correcting mode: reads pass through the corrector; read errors are never written back.
// R9 - Correcting mode: corrector stays in latch-and-correct mode for every read.
// R10 - Two banks of 39 bits each: 32 data plus 7 check.
// R11 - Address bit four selects the bank, interleaving every four words.
// R12 - Address bits three and two drive the top row and column inputs.
// R13 - Burst wraps word offset within the nibble; bank bit never changes.
// R14 - Low address bits and size decode into four byte strobes.
// R15 - Port A, port B and refresh arbitrated with no outside logic.
// R16 - Wait states while precharge pends, refresh runs or other port owns memory.
// R17 - Each port's address and strobes sit behind enableable buffers.
// R18 - Monitoring mode: single and first burst reads last seven clocks, direct data.
// R19 - Monitoring mode error: fault and suspend low until corrected word written back.
// R20 - After a retry the processor waits for suspend release, then retries.
// R21 - Monitoring mode burst data held in registered transceivers until sampled.
// R22 - Back-to-back same-bank accesses wait for row precharge.
`timescale 1ns/1ps
`default_nettype none
`include "edac_glue_consts.svh"
module edac_glue
  import edac_glue_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       monitor_mode_pin,
  input  wire logic [1:0] port_cs_n,
  input  wire logic [1:0] write_request_n,
  input  wire logic [1:0] port_burst_n,
  input  wire logic [9:0] port_addr,
  input  wire logic [3:0] port_siz,
  input  wire logic       refresh_req_n,
  input  wire logic       edac_error,
  output logic      [1:0] sync_cycle_end_n,
  output logic      [1:0] cycle_fault_n,
  output logic      [1:0] suspend_n,
  output logic      [1:0] port_buf_oe_n,
  output logic            mem_access_n,
  output logic            mem_refresh_n,
  output logic            mem_write_n,
  output logic            bank_select_input,
  output logic      [1:0] nibble_addr,
  output logic      [3:0] byte_column_strobes_n,
  output logic            edac_latch_correct,
  output logic            edac_cpu_oe_n,
  output logic            edac_mem_oe_n,
  output logic            direct_oe_n,
  output logic            xcvr_capture
);
  // Address width of one port's slice, then data, check and bank widths of the memory.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;
  localparam int CHECK_W = 7;
  localparam int BANK_W = DATA_W + CHECK_W; // R10
  // Refused while the design is built, before any clock runs.
  if (ADDR_W != `BANK_BIT + 1 || BANK_W != 39) begin : g_width_check
    $error("edac_glue: address or bank width unsupported");
  end

  state_t      state_q;
  state_t      state_d;
  owner_t      owner_q;
  owner_t      owner_d;
  logic  [3:0] cnt_q;
  logic  [3:0] cnt_d;
  logic  [3:0] len_q;
  logic  [3:0] len_d;
  logic  [1:0] words_q;
  logic  [1:0] words_d;
  logic  [1:0] nib_q;
  logic  [1:0] nib_d;
  logic        bank_q;
  logic        bank_d;
  logic  [3:0] mask_q;
  logic  [3:0] mask_d;
  logic        write_q;
  logic        write_d;
  logic        burst_q;
  logic        burst_d;
  logic        err_q;
  logic        err_d;
  logic  [3:0] prechg_q;
  logic  [3:0] prechg_d;
  logic        last_bank_q;
  logic        last_bank_d;
  logic        mon_meta_q;
  logic        mon_q;

  arb_if arb ();

  edac_arbiter u_arb (
    .clk     (clk),
    .sys_rst (sys_rst),
    .arb     (arb)
  );

  // Byte strobe decode from the two low address bits and transfer size.
  function automatic logic [3:0] byte_mask(input logic [1:0] a10, input logic [1:0] siz);
    logic [3:0] m;
    m = `MASK_ALL;
    case (siz)
      `SIZ_BYTE:   m = 4'h8 >> a10;
      `SIZ_WORD:   m = 4'hc >> a10;
      `SIZ_TRIPLE: m = 4'he >> a10;
      `SIZ_LONG:   m = 4'hf >> a10;
      default:     m = `MASK_ALL;
    endcase
    return m;
  endfunction

  function automatic logic [3:0] cycle_len(input logic wr, input logic [3:0] m, input logic mon);
    logic [3:0] n;
    n = `READ_CLKS; // R1
    if (wr) begin
      n = (m == `MASK_ALL) ? `WRITE_CLKS : `BYTE_WRITE_CLKS; // R2 R3
    end else if (mon) begin
      n = `READ_MON_CLKS; // R18
    end
    return n;
  endfunction

  // Port slices picked by the arbiter's grant.
  wire       sel_b     = (arb.grant == OWN_B);
  wire [4:0] sel_addr  = sel_b ? port_addr[9:5] : port_addr[4:0];
  wire [1:0] sel_siz   = sel_b ? port_siz[3:2] : port_siz[1:0];
  wire       sel_wr    = sel_b ? ~write_request_n[1] : ~write_request_n[0];
  wire       sel_burst = sel_b ? ~port_burst_n[1] : ~port_burst_n[0];
  wire [3:0] sel_mask  = byte_mask(sel_addr[1:0], sel_siz); // R14
  wire [3:0] sel_len   = cycle_len(sel_wr, sel_mask, mon_q);

  // A port aimed at the bank still precharging is held off; the other bank may go.
  wire       prechg    = (prechg_q != `MASK_NONE);
  wire       a_hit     = prechg & (port_addr[`BANK_BIT] == last_bank_q);
  wire       b_hit     = prechg & (port_addr[ADDR_W + `BANK_BIT] == last_bank_q);
  assign arb.req     = {~port_cs_n[1] & ~b_hit, ~port_cs_n[0] & ~a_hit}; // R22
  assign arb.req_ref = ~refresh_req_n & ~prechg;
  assign arb.ready   = (state_q == ST_IDLE); // R15 R16

  wire busy_cpu   = (state_q == ST_ACCESS) | (state_q == ST_BURST);
  wire last_clk   = (cnt_q == len_q - 4'h1);
  wire mon_read   = mon_q & ~write_q & (state_q == ST_ACCESS);
  wire sample_err = mon_read & (cnt_q == len_q - `ERR_SAMPLE_BACK);
  wire scrub_chk  = (state_q == ST_SCRUB) & (cnt_q == `SCRUB_CHECK_CNT);

  always_comb begin
    state_d     = state_q;
    owner_d     = owner_q;
    cnt_d       = cnt_q + 4'h1;
    len_d       = len_q;
    words_d     = words_q;
    nib_d       = nib_q;
    bank_d      = bank_q;
    mask_d      = mask_q;
    write_d     = write_q;
    burst_d     = burst_q;
    err_d       = err_q;
    prechg_d    = prechg ? prechg_q - 4'h1 : prechg_q;
    last_bank_d = last_bank_q;
    if (sample_err | scrub_chk) begin
      err_d = edac_error;
    end
    if (scrub_chk & edac_error) begin
      len_d = `SCRUB_ERR_CLKS; // R5
    end
    case (state_q)
      ST_IDLE: begin
        cnt_d = 4'h0;
        err_d = 1'b0;
        if (arb.grant == OWN_REF) begin
          state_d = ST_SCRUB;
          owner_d = OWN_REF;
          len_d   = `SCRUB_CLKS; // R5
        end else if (arb.grant != OWN_NONE) begin
          state_d = ST_ACCESS;
          owner_d = arb.grant;
          len_d   = sel_len;
          write_d = sel_wr;
          burst_d = sel_burst & ~sel_wr;
          mask_d  = sel_wr ? sel_mask : `MASK_ALL;
          bank_d  = sel_addr[`BANK_BIT]; // R11
          nib_d   = sel_addr[`NIB_HI:`NIB_LO]; // R12
          words_d = `BURST_EXTRA;
        end
      end
      ST_ACCESS: begin
        if (last_clk) begin
          cnt_d = 4'h0;
          if (mon_q & ~write_q & err_q) begin
            state_d = ST_FIXUP; // R19
            len_d   = `FIXUP_CLKS;
          end else if (burst_q) begin
            state_d = ST_BURST;
            len_d   = `BURST_WORD_CLKS; // R4
            nib_d   = nib_q + 2'h1; // R13
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_BURST: begin
        if (last_clk) begin
          cnt_d   = 4'h0;
          words_d = words_q - 2'h1;
          nib_d   = nib_q + 2'h1; // R13
          if (words_q == 2'h1) begin
            state_d = ST_IDLE;
          end
        end
      end
      ST_SCRUB, ST_FIXUP: begin
        if (last_clk) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (state_d == ST_IDLE && state_q != ST_IDLE) begin
      owner_d     = OWN_NONE;
      prechg_d    = `PRECHARGE_CLKS; // R16 R22
      last_bank_d = bank_q;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q     <= ST_IDLE;
      owner_q     <= OWN_NONE;
      cnt_q       <= 4'h0;
      len_q       <= 4'h0;
      words_q     <= 2'h0;
      nib_q       <= 2'h0;
      bank_q      <= 1'b0;
      mask_q      <= `MASK_NONE;
      write_q     <= 1'b0;
      burst_q     <= 1'b0;
      err_q       <= 1'b0;
      prechg_q    <= 4'h0;
      last_bank_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      owner_q     <= owner_d;
      cnt_q       <= cnt_d;
      len_q       <= len_d;
      words_q     <= words_d;
      nib_q       <= nib_d;
      bank_q      <= bank_d;
      mask_q      <= mask_d;
      write_q     <= write_d;
      burst_q     <= burst_d;
      err_q       <= err_d;
      prechg_q    <= prechg_d;
      last_bank_q <= last_bank_d;
    end
  end

  // The mode strap comes from a pin, so it is synchronised before use.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_meta_q <= 1'b0;
      mon_q      <= 1'b0;
    end else begin
      mon_meta_q <= monitor_mode_pin;
      mon_q      <= mon_meta_q;
    end
  end

  wire own_a   = (owner_q == OWN_A);
  wire own_b   = (owner_q == OWN_B);
  wire retry   = mon_q & err_q & ~write_q & ((state_q == ST_ACCESS) | (state_q == ST_FIXUP));
  wire end_cyc = busy_cpu & last_clk & ~retry;
  wire scrub_wb = (state_q == ST_SCRUB) & err_q & (cnt_q >= `SCRUB_CLKS);
  wire reading = busy_cpu & ~write_q;

  // A cycle with a detected error in monitoring mode is retried, never terminated.
  assign sync_cycle_end_n[0] = ~(end_cyc & own_a); // R7
  assign sync_cycle_end_n[1] = ~(end_cyc & own_b); // R7
  assign cycle_fault_n[0]    = ~(retry & own_a); // R19
  assign cycle_fault_n[1]    = ~(retry & own_b); // R19
  assign suspend_n[0]        = ~(retry & own_a); // R19
  assign suspend_n[1]        = ~(retry & own_b); // R19
  assign port_buf_oe_n[0]    = ~own_a;
  assign port_buf_oe_n[1]    = ~own_b;

  assign mem_access_n          = ~(busy_cpu | (state_q == ST_FIXUP));
  assign mem_refresh_n         = ~(state_q == ST_SCRUB);
  assign mem_write_n           = ~((busy_cpu & write_q) | (state_q == ST_FIXUP) | scrub_wb); // R5
  assign bank_select_input     = bank_q; // R11
  assign nibble_addr           = nib_q; // R12 R13
  assign byte_column_strobes_n = busy_cpu ? ~mask_q : `MASK_ALL; // R14
  // Correcting mode latches every read so the column strobe may move on early.
  assign edac_latch_correct    = reading ? ~mon_q : (state_q == ST_SCRUB); // R9
  assign edac_cpu_oe_n         = ~(reading & ~mon_q); // R8
  assign edac_mem_oe_n         = ~((state_q == ST_FIXUP) | scrub_wb); // R8 R19
  assign direct_oe_n           = ~(reading & mon_q); // R18
  assign xcvr_capture          = reading & mon_q & (cnt_q == len_q - `ERR_SAMPLE_BACK); // R21
endmodule
`default_nettype wire

// *** edac_glue_props.sv ***
// Port-level timing and ownership checks for the dual-port EDAC glue.
`timescale 1ns/1ps
`default_nettype none
module edac_glue_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       monitor_mode_pin,
  input wire logic [1:0] write_request_n,
  input wire logic [1:0] port_burst_n,
  input wire logic [9:0] port_addr,
  input wire logic [3:0] port_siz,
  input wire logic [1:0] sync_cycle_end_n,
  input wire logic [1:0] cycle_fault_n,
  input wire logic [1:0] suspend_n,
  input wire logic [1:0] port_buf_oe_n,
  input wire logic       mem_refresh_n,
  input wire logic       mem_write_n,
  input wire logic       bank_select_input,
  input wire logic [1:0] nibble_addr,
  input wire logic [3:0] byte_column_strobes_n,
  input wire logic       edac_latch_correct,
  input wire logic       edac_cpu_oe_n,
  input wire logic       mem_access_n,
  input wire logic       edac_mem_oe_n,
  input wire logic       direct_oe_n,
  input wire logic       xcvr_capture
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // The mode pin is only changed while idle, so its raw level stands for the synced one.
  wire rd_a = write_request_n[0] & port_burst_n[0] & ~monitor_mode_pin;
  a_read_length: assert property (
    $fell(port_buf_oe_n[0]) && rd_a |-> sync_cycle_end_n[0] [*7] ##1 !sync_cycle_end_n[0])
    else $error("single read not ended in cycle eight");
  a_write_length: assert property (
    $fell(port_buf_oe_n[0]) && !write_request_n[0] && port_siz[1:0] == 2'h0
    |-> sync_cycle_end_n[0] [*4] ##1 !sync_cycle_end_n[0])
    else $error("word write not ended in cycle five");
  a_byte_write_length: assert property (
    $fell(port_buf_oe_n[0]) && !write_request_n[0] && port_siz[1:0] == 2'h1
    |-> ($countones(~byte_column_strobes_n) <= 1 && sync_cycle_end_n[0]) [*8]
    ##1 !sync_cycle_end_n[0])
    else $error("byte write length or lanes wrong");
  a_monitor_read_end: assert property (
    $fell(port_buf_oe_n[0]) && write_request_n[0] && monitor_mode_pin
    |-> ##6 (sync_cycle_end_n[0] ^ cycle_fault_n[0]))
    else $error("monitor read not ended or faulted in cycle seven");
  a_burst_word_spacing: assert property (
    $fell(port_buf_oe_n[1]) && write_request_n[1] && !port_burst_n[1] && !monitor_mode_pin
    |-> ##7 !sync_cycle_end_n[1] ##4 !sync_cycle_end_n[1] ##4 !sync_cycle_end_n[1]
    ##4 !sync_cycle_end_n[1])
    else $error("burst words not four clocks apart");
  a_scrub_length: assert property (
    $fell(mem_refresh_n) |-> !mem_refresh_n [*6] ##1
    (mem_refresh_n or (!mem_refresh_n ##1 !mem_refresh_n ##1 mem_refresh_n)))
    else $error("scrub not six or eight clocks");
  a_read_corrector_path: assert property (
    !port_buf_oe_n[0] && rd_a |-> mem_write_n && edac_latch_correct && !edac_cpu_oe_n)
    else $error("read not latched through corrector");
  a_bank_nibble_load: assert property (
    $fell(port_buf_oe_n[0])
    |-> bank_select_input == port_addr[4] && nibble_addr == port_addr[3:2])
    else $error("bank or nibble address not from port address");
  a_burst_bank_hold: assert property (
    !port_buf_oe_n[1] && !$fell(port_buf_oe_n[1]) |-> $stable(bank_select_input))
    else $error("bank changed within an access");
  a_single_owner: assert property (
    port_buf_oe_n != 2'h0 && (mem_refresh_n || port_buf_oe_n == 2'h3))
    else $error("two owners of memory at once");
  a_retry_pair_hold: assert property (
    $fell(cycle_fault_n[0]) |-> !(suspend_n[0] | cycle_fault_n[0]) ##1
    (!(suspend_n[0] | cycle_fault_n[0]) && !mem_write_n) [*2] ##1
    (suspend_n[0] && cycle_fault_n[0]))
    else $error("retry pair not held through write-back");
  a_fixup_writes_back: assert property (
    $fell(cycle_fault_n[0])
    |-> ##1 (!edac_mem_oe_n && !mem_write_n && !mem_access_n) [*2])
    else $error("corrected word not written back during retry");
  a_monitor_direct_path: assert property (
    !port_buf_oe_n[0] && write_request_n[0] && monitor_mode_pin && mem_write_n
    |-> !direct_oe_n && edac_cpu_oe_n)
    else $error("monitor read not routed straight to the processor");
  a_capture_point: assert property (
    $fell(port_buf_oe_n[0]) && write_request_n[0] && monitor_mode_pin
    |-> !xcvr_capture [*5] ##1 xcvr_capture)
    else $error("read data not captured in cycle six");
  a_scrub_corrector_drive: assert property (
    !mem_refresh_n && !mem_write_n |-> !edac_mem_oe_n)
    else $error("scrub write-back without corrector drive");
  a_access_with_owner: assert property (
    port_buf_oe_n != 2'h3 |-> !mem_access_n)
    else $error("port owns memory without a memory access");
endmodule
bind edac_glue edac_glue_props i_edac_glue_props (.clk, .sys_rst, .monitor_mode_pin,
  .write_request_n, .port_burst_n, .port_addr, .port_siz, .sync_cycle_end_n, .cycle_fault_n,
  .suspend_n, .port_buf_oe_n, .mem_refresh_n, .mem_write_n, .bank_select_input, .nibble_addr,
  .byte_column_strobes_n, .edac_latch_correct, .edac_cpu_oe_n, .mem_access_n, .edac_mem_oe_n,
  .direct_oe_n, .xcvr_capture);
`default_nettype wire

// *** cpu_port_model.sv ***
// One processor port: holds a request until terminated and backs off on a retry.
`timescale 1ns/1ps
`default_nettype none
module cpu_port_model (
  input  wire logic clk,
  input  wire logic go,
  input  wire logic wr,
  input  wire logic bst,
  input  wire logic end_n,
  input  wire logic fault_n,
  input  wire logic susp_n,
  output logic      cs_n,
  output logic      wr_n,
  output logic      burst_n,
  output logic      busy
);
  logic       req_q;
  logic       hit_q;
  logic       flt_q;
  logic [1:0] words;
  initial begin
    {cs_n, wr_n, burst_n, busy} = 4'he;
  end
  always @(posedge clk) begin
    req_q <= go;
    hit_q <= !cs_n && !end_n;
    flt_q <= !cs_n && !fault_n;
  end
  always @(negedge clk) begin
    if (req_q && !busy) begin
      busy <= 1'b1;
      words <= 2'h0;
      cs_n <= 1'b0;
      wr_n <= !wr;
      burst_n <= !bst;
    end else if (busy && flt_q) begin
      cs_n <= 1'b1;
    end else if (busy && cs_n && susp_n) begin
      cs_n <= 1'b0;
    end else if (hit_q) begin
      words <= words + 2'h1;
      if (wr || !bst || words == 2'h3) begin
        busy <= 1'b0;
        // Released lines float; show the opposite level, not the last one.
        cs_n <= 1'b1;
        wr_n <= ~wr_n;
        burst_n <= ~burst_n;
      end
    end
  end
endmodule
`default_nettype wire

// *** dual_port_edac_dram_glue_bench.sv ***
// Self-checking bench for the dual-port EDAC memory glue.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, a, e); end end
module dual_port_edac_dram_glue_bench;
  logic       clk, sys_rst, monitor_mode_pin, refresh_req_n, edac_error, flt;
  logic [1:0] go, wr, bst, sync_cycle_end_n, cycle_fault_n, suspend_n, port_buf_oe_n;
  logic [1:0] nibble_addr;
  wire  [1:0] port_cs_n, write_request_n, port_burst_n, busy;
  logic [9:0] port_addr;
  logic [3:0] port_siz, byte_column_strobes_n;
  logic       mem_access_n, mem_refresh_n, mem_write_n, bank_select_input;
  logic       edac_latch_correct, edac_cpu_oe_n, edac_mem_oe_n, direct_oe_n, xcvr_capture;
  logic [2:0] nibs [4];
  int         errors, comparisons, wc;
  edac_glue i_edac_glue (.clk, .sys_rst, .monitor_mode_pin, .port_cs_n, .write_request_n,
    .port_burst_n, .port_addr, .port_siz, .refresh_req_n, .edac_error, .sync_cycle_end_n,
    .cycle_fault_n, .suspend_n, .port_buf_oe_n, .mem_access_n, .mem_refresh_n, .mem_write_n,
    .bank_select_input, .nibble_addr, .byte_column_strobes_n, .edac_latch_correct,
    .edac_cpu_oe_n, .edac_mem_oe_n, .direct_oe_n, .xcvr_capture);
  for (genvar g = 0; g < 2; g++) begin : g_cpu
    cpu_port_model i_cpu_port_model (.clk, .go(go[g]), .wr(wr[g]), .bst(bst[g]),
      .end_n(sync_cycle_end_n[g]), .fault_n(cycle_fault_n[g]), .susp_n(suspend_n[g]),
      .cs_n(port_cs_n[g]), .wr_n(write_request_n[g]), .burst_n(port_burst_n[g]),
      .busy(busy[g]));
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Returns clocks from grant to the last termination and the grant time.
  task automatic acc(input int p, input logic [4:0] a, input logic [1:0] sz,
                     input logic w, input logic b, output int n, output time st);
    int k;
    int m;
    m = 0;
    n = 0;
    st = 0;
    wc = 0;
    port_addr[p*5+:5] = a;
    port_siz[p*2+:2] = sz;
    wr[p] = w;
    bst[p] = b;
    go[p] = 1'b1;
    @(negedge clk);
    go[p] = 1'b0;
    @(negedge clk);
    for (k = 0; k < 400 && busy[p]; k++) begin
      if (!port_buf_oe_n[p] && st == 0)
        st = $time;
      if (st != 0)
        m++;
      if (!sync_cycle_end_n[p]) begin
        n = m;
        nibs[wc] = {bank_select_input, nibble_addr};
        wc++;
      end
      if (!cycle_fault_n[p]) begin
        edac_error = 1'b0;
        flt = 1'b1;
      end
      @(negedge clk);
    end
    `CHK(busy[p], 1'b0)
  endtask
  task automatic t_single;
    int n;
    time st;
    acc(0, 5'h00, 2'h0, 1'b0, 1'b0, n, st);
    `CHK(n, 8)
    acc(0, 5'h10, 2'h0, 1'b1, 1'b0, n, st);
    `CHK(n, 5)
    acc(0, 5'h02, 2'h1, 1'b1, 1'b0, n, st);
    `CHK(n, 9)
    $display("single accesses done");
  endtask
  task automatic t_burst;
    int n;
    time st;
    acc(1, 5'h18, 2'h0, 1'b0, 1'b1, n, st);
    `CHK(n, 20)
    for (int i = 0; i < 4; i++)
      `CHK(nibs[i], {1'b1, 2'(i + 2)})
    $display("burst done");
  endtask
  task automatic t_arb;
    time sa, sb, g1;
    int na, nb;
    repeat (5) @(negedge clk);
    fork
      acc(0, 5'h00, 2'h0, 1'b0, 1'b0, na, sa);
      acc(1, 5'h00, 2'h0, 1'b0, 1'b0, nb, sb);
    join
    `CHK(sb < sa, 1'b1)
    g1 = sa - sb;
    repeat (5) @(negedge clk);
    fork
      acc(0, 5'h00, 2'h0, 1'b0, 1'b0, na, sa);
      acc(1, 5'h10, 2'h0, 1'b0, 1'b0, nb, sb);
    join
    `CHK(sa < sb, 1'b1)
    `CHK(g1 > sb - sa, 1'b1)
    $display("arbitration done");
  endtask
  task automatic t_scrub(input logic e, input int exp_n);
    int k;
    int n;
    int w;
    n = 0;
    w = 0;
    edac_error = e;
    refresh_req_n = 1'b0;
    for (k = 0; k < 50 && mem_refresh_n; k++)
      @(negedge clk);
    refresh_req_n = 1'b1;
    for (k = 0; k < 50 && !mem_refresh_n; k++) begin
      n++;
      w += !mem_write_n;
      @(negedge clk);
    end
    edac_error = 1'b0;
    `CHK(n, exp_n)
    `CHK(w, e ? 2 : 0)
    $display("scrub done");
  endtask
  task automatic t_mon;
    int n;
    time st;
    monitor_mode_pin = 1'b1;
    repeat (4) @(negedge clk);
    acc(0, 5'h08, 2'h0, 1'b0, 1'b0, n, st);
    `CHK(n, 7)
    flt = 1'b0;
    edac_error = 1'b1;
    acc(0, 5'h04, 2'h0, 1'b0, 1'b0, n, st);
    `CHK(flt, 1'b1)
    `CHK(wc, 1)
    monitor_mode_pin = 1'b0;
    repeat (4) @(negedge clk);
    $display("monitor mode done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  initial begin
    {sys_rst, refresh_req_n} = 2'h3;
    {monitor_mode_pin, edac_error, flt, go, wr, bst} = '0;
    {port_addr, port_siz} = '0;
    errors = 0;
    comparisons = 0;
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_single;
    t_burst;
    t_arb;
    t_scrub(1'b0, 6);
    t_scrub(1'b1, 8);
    t_mon;
    report_and_stop;
  end
endmodule
`default_nettype wire
